// [verilog/sis_map.vh]
// Operation
// - with encoder fitted and stall check on, compare positions always
// - stall when encoder and motor differ by over 45 degrees
// - stall shows as a status bit for the host
// - stall invalidates position; absolute moves refused until preset
// - a running move is ended when a stall is declared
// - warning bit when temperature nears the limit
// - motor power cut when driver temperature exceeds 95 C
// - run current 0.1 to 3.4 A in 0.1 A steps
// - idle current 0 to 100 percent of run current, a to value
// - idle current regulated as peak, not RMS
// - two discrete inputs, each with a programmable function
// - each input has a programmable active level
// - registration jogs, then runs programmed steps after a stop request
// - blend runs segments back to back without halting
// - dwell runs segments with a programmed pause between them
// - indexer move stored, started by a programmed input
// - hold suspends the move and keeps the position count
// - resume restarts the held move where it stopped
// - immediate stop halts all motion without a ramp
// - idle current after 1.5 s without motion, full on motion
// - indexer start only on inactive-to-active input edge
`ifndef SIS_MAP_VH
`define SIS_MAP_VH
`define SIS_A_CTRL   6'h00
`define SIS_A_CMD    6'h01
`define SIS_A_TGT    6'h02
`define SIS_A_SEG    6'h03
`define SIS_A_DWELL  6'h04
`define SIS_A_CUR    6'h05
`define SIS_A_INCFG  6'h06
`define SIS_A_STAT   6'h07
`define SIS_A_MPOS   6'h08
`define SIS_A_EPOS   6'h09
`define SIS_A_SCALE  6'h0A
`define SIS_A_PER    6'h0B
`define SIS_C_REG    4'h1
`define SIS_C_BLEND  4'h2
`define SIS_C_DWELL  4'h3
`define SIS_C_INDEX  4'h4
`define SIS_C_HOLD   4'h5
`define SIS_C_RESUME 4'h6
`define SIS_C_ISTOP  4'h7
`define SIS_C_ABS    4'h8
`define SIS_C_PRESET 4'h9
`define SIS_C_CSTOP  4'hA
`define SIS_C_REL    4'hB
`define SIS_F_START  2'h1
`define SIS_F_CSTOP  2'h2
`define SIS_F_ESTOP  2'h3
`define SIS_TEMP_MAX 8'h5F
`define SIS_TEMP_WRN 8'h5A
`define SIS_CUR_MAX  6'h22
`define SIS_CUR_MIN  6'h01
`define SIS_PCT_MAX  7'h64
`define SIS_IDLE_MS  1500
`define SIS_CLK_KHZ  250000
`define SIS_US_CYC   250
`define SIS_RST_PER  16'h0FA0
`define SIS_RST_SCL  32'h0400_0C80
`define SIS_RST_CUR  32'h0000_0A0A
`endif

// [verilog/sis_top.v]
`timescale 1ns/100ps
`include "sis_map.vh"
module sis_top #(
  parameter IDLE_CYC = `SIS_IDLE_MS * `SIS_CLK_KHZ
) (
  input  wire        sys_clk_i,
  input  wire        rst_n_i,
  input  wire [31:0] wb_adr_i,
  input  wire [31:0] wb_dat_i,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg  [31:0] wb_dat_o,
  output reg         wb_ack_o,
  input  wire [1:0]  din_i,
  input  wire        enc_fitted_i,
  input  wire [31:0] enc_pos_i,
  input  wire [7:0]  temp_i,
  output reg         step_o,
  output reg         dir_o,
  output reg         motor_en_o,
  output reg         peak_mode_o,
  output reg  [12:0] cur_ma_o
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam S_IDLE = 3'd0;
  localparam S_RUN  = 3'd1;
  localparam S_JOG  = 3'd2;
  localparam S_DWL  = 3'd3;
  localparam S_HOLD = 3'd4;

  function [31:0] be_merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0]  sel;
    integer k;
    begin
      be_merge = old;
      for (k = 0; k < 4; k = k + 1)
        if (sel[k]) be_merge[k*8 +: 8] = nw[k*8 +: 8];
    end
  endfunction

  function [31:0] mag;
    input [31:0] v;
    begin
      mag = v[31] ? (32'h0 - v) : v;
    end
  endfunction

  // ------------------------------------------------------------
  // input synchronisers
  // ------------------------------------------------------------
  reg  [1:0]  din_s1, din_s2, din_q;
  reg         fit_s1, fit_s2;
  reg  [31:0] enc_s1, enc_s2;
  reg  [7:0]  tmp_s1, tmp_s2;
  reg  [31:0] ctrl, tgt, dwell, cur, incfg, scale, per;
  reg  [31:0] seg [0:3];
  reg  [31:0] mpos;
  reg  [2:0]  st, hold_st;
  reg  [31:0] rem, tmr;
  reg  [1:0]  seg_i, seg_n;
  reg         dir, blend, stop_req, idx_pend, idx_dir;
  reg  [31:0] idx_rem;
  reg         stall, invalid, cmd_err, ot_warn, ot_fault;
  reg  [31:0] idle_cnt;
  reg         idle;
  reg  [15:0] stp_cnt;
  wire [1:0]  din_act;
  wire [1:0]  rise;
  wire        estop;

  always @(posedge sys_clk_i) begin
    din_s1 <= din_i;
    din_s2 <= din_s1;
    fit_s1 <= enc_fitted_i;
    fit_s2 <= fit_s1;
    enc_s1 <= enc_pos_i;
    enc_s2 <= enc_s1;
    tmp_s1 <= temp_i;
    tmp_s2 <= tmp_s1;
  end

  // ------------------------------------------------------------
  // input conditioning, per channel
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1) begin : g_in
      // level bit 1 makes the input active low (normally closed)
      assign din_act[g] = din_s2[g] ^ incfg[g*4+3];
      assign rise[g] = din_act[g] & ~din_q[g];
    end
  endgenerate

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      din_q <= 2'h0;
    end else begin
      din_q <= din_act;
    end
  end

  function func_hit;
    input [1:0] r;
    input [1:0] act;
    input [7:0] cfg;
    input [1:0] f;
    begin
      func_hit = (r[0] && cfg[1:0] == f) || (r[1] && cfg[5:4] == f);
    end
  endfunction

  wire start_ev = func_hit(rise, 2'b11, incfg[7:0], `SIS_F_START);
  wire cstop_ev = func_hit(rise, 2'b11, incfg[7:0], `SIS_F_CSTOP);
  assign estop  = func_hit(din_act, 2'b11, incfg[7:0], `SIS_F_ESTOP);

  // ------------------------------------------------------------
  // stall comparison, in units of steps times encoder counts
  // ------------------------------------------------------------
  wire [15:0] spt = scale[15:0];
  wire [15:0] cpt = scale[31:16];
  wire [47:0] e_x = {{16{enc_s2[31]}}, enc_s2} * {32'h0, spt};
  wire [47:0] m_x = {{16{mpos[31]}}, mpos} * {32'h0, cpt};
  wire [47:0] dif = e_x - m_x;
  wire [47:0] adif = dif[47] ? (48'h0 - dif) : dif;
  wire [47:0] lim = ({32'h0, spt} * {32'h0, cpt}) >> 3;
  wire stall_ev = fit_s2 & ctrl[0] & (adif > lim);

  // ------------------------------------------------------------
  // bus slave
  // ------------------------------------------------------------
  wire       req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  wire       wr  = req & wb_we_i;
  wire [5:0] ra  = wb_adr_i[7:2];
  wire       hit = (wb_adr_i[31:8] == 24'h0);
  wire       cmd_w = wr & hit & (ra == `SIS_A_CMD);
  wire [3:0] cmd   = wb_dat_i[3:0];
  wire [31:0] stat = {21'h0, idx_pend, idle, st == S_HOLD, st != S_IDLE,
                      din_act, ot_fault, ot_warn, cmd_err, invalid, stall};

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0;
      ctrl  <= 32'h0;
      tgt   <= 32'h0;
      dwell <= 32'h0;
      cur   <= `SIS_RST_CUR;
      incfg <= 32'h0;
      scale <= `SIS_RST_SCL;
      per   <= {16'h0, `SIS_RST_PER};
    end else begin
      wb_ack_o <= req;
      if (req) begin
        case (ra)
          `SIS_A_CTRL:  wb_dat_o <= ctrl;
          `SIS_A_TGT:   wb_dat_o <= tgt;
          `SIS_A_SEG:   wb_dat_o <= seg[tgt[1:0]];
          `SIS_A_DWELL: wb_dat_o <= dwell;
          `SIS_A_CUR:   wb_dat_o <= cur;
          `SIS_A_INCFG: wb_dat_o <= incfg;
          `SIS_A_STAT:  wb_dat_o <= stat;
          `SIS_A_MPOS:  wb_dat_o <= mpos;
          `SIS_A_EPOS:  wb_dat_o <= enc_s2;
          `SIS_A_SCALE: wb_dat_o <= scale;
          `SIS_A_PER:   wb_dat_o <= per;
          default:      wb_dat_o <= 32'h0;
        endcase
        if (!hit) wb_dat_o <= 32'h0;
      end
      if (wr && hit) begin
        case (ra)
          `SIS_A_CTRL:  ctrl <= be_merge(ctrl, wb_dat_i, wb_sel_i) & 32'h1;
          `SIS_A_TGT:   tgt <= be_merge(tgt, wb_dat_i, wb_sel_i);
          `SIS_A_DWELL: dwell <= be_merge(dwell, wb_dat_i, wb_sel_i);
          `SIS_A_CUR: begin
            // out-of-range settings clamp to the nearest legal value
            cur[5:0] <= (wb_dat_i[5:0] > `SIS_CUR_MAX) ? `SIS_CUR_MAX :
                        (wb_dat_i[5:0] < `SIS_CUR_MIN) ? `SIS_CUR_MIN :
                        wb_dat_i[5:0];
            cur[14:8] <= (wb_dat_i[14:8] > `SIS_PCT_MAX) ? `SIS_PCT_MAX :
                         wb_dat_i[14:8];
          end
          `SIS_A_INCFG: incfg <= be_merge(incfg, wb_dat_i, wb_sel_i) & 32'hBB;
          `SIS_A_SCALE: scale <= be_merge(scale, wb_dat_i, wb_sel_i);
          `SIS_A_PER:   per <= be_merge(per, wb_dat_i, wb_sel_i) & 32'hFFFF;
          default: ;
        endcase
      end
    end
  end

  always @(posedge sys_clk_i) begin
    if (wr && hit && ra == `SIS_A_SEG) seg[tgt[1:0]] <= wb_dat_i;
  end

  // ------------------------------------------------------------
  // motion sequencer
  // ------------------------------------------------------------
  wire step_tick = (stp_cnt == 16'h0);
  wire moving = (st == S_RUN) | (st == S_JOG);
  wire blocked = estop | ot_fault | stall_ev;

  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      st <= S_IDLE;
      hold_st <= S_IDLE;
      rem <= 32'h0;
      tmr <= 32'h0;
      seg_i <= 2'h0;
      seg_n <= 2'h0;
      dir <= 1'b0;
      blend <= 1'b0;
      stop_req <= 1'b0;
      idx_pend <= 1'b0;
      idx_dir <= 1'b0;
      idx_rem <= 32'h0;
      mpos <= 32'h0;
      stp_cnt <= 16'h0;
      step_o <= 1'b0;
      dir_o <= 1'b0;
      stall <= 1'b0;
      invalid <= 1'b0;
      cmd_err <= 1'b0;
    end else begin
      step_o <= 1'b0;
      dir_o <= dir;
      stp_cnt <= (moving && !step_tick) ? stp_cnt - 16'h1 : per[15:0];
      // stall and cmd_err status bits are write-one-to-clear; a new event in the same cycle wins
      if (wr && hit && ra == `SIS_A_STAT) begin
        stall <= stall & ~wb_dat_i[0];
        cmd_err <= cmd_err & ~wb_dat_i[2];
      end
      if (moving && step_tick && !blocked) begin
        step_o <= 1'b1;
        mpos <= dir ? mpos - 32'h1 : mpos + 32'h1;
        if (st == S_RUN) rem <= rem - 32'h1;
      end
      case (st)
        S_RUN: if (rem == 32'h0) begin
          if (seg_i != seg_n) begin
            seg_i <= seg_i + 2'h1;
            rem <= mag(seg[seg_i + 2'h1]);
            dir <= seg[seg_i + 2'h1][31];
            tmr <= dwell;
            st <= blend ? S_RUN : S_DWL;
          end else begin
            st <= S_IDLE;
          end
        end
        S_JOG: if (stop_req || cstop_ev) begin
          rem <= mag(tgt);
          seg_n <= 2'h0;
          seg_i <= 2'h0;
          st <= S_RUN;
        end
        S_DWL: begin
          if (tmr == 32'h0) st <= S_RUN;
          else tmr <= tmr - 32'h1;
        end
        S_IDLE, S_HOLD: ;
        default: st <= S_IDLE;
      endcase
      stop_req <= 1'b0;
      if (cmd_w) begin
        case (cmd)
          `SIS_C_REG: if (st == S_IDLE && !estop) begin
            dir <= wb_dat_i[4];
            st <= S_JOG;
          end
          `SIS_C_BLEND, `SIS_C_DWELL: if (st == S_IDLE && !estop) begin
            blend <= (cmd == `SIS_C_BLEND);
            seg_n <= wb_dat_i[9:8];
            seg_i <= 2'h0;
            rem <= mag(seg[0]);
            dir <= seg[0][31];
            st <= S_RUN;
          end
          `SIS_C_INDEX: begin
            idx_pend <= 1'b1;
            idx_rem <= mag(tgt);
            idx_dir <= tgt[31];
          end
          `SIS_C_HOLD: if (moving || st == S_DWL) begin
            hold_st <= st;
            st <= S_HOLD;
          end
          `SIS_C_RESUME: if (st == S_HOLD && !estop) st <= hold_st;
          `SIS_C_ISTOP: begin
            st <= S_IDLE;
            idx_pend <= 1'b0;
          end
          `SIS_C_ABS: if (invalid) begin
            cmd_err <= 1'b1;
          end else if (st == S_IDLE && !estop) begin
            rem <= mag(tgt - mpos);
            dir <= $signed(tgt) < $signed(mpos);
            seg_n <= 2'h0;
            seg_i <= 2'h0;
            st <= S_RUN;
          end
          `SIS_C_REL: if (st == S_IDLE && !estop) begin
            rem <= mag(tgt);
            dir <= tgt[31];
            seg_n <= 2'h0;
            seg_i <= 2'h0;
            st <= S_RUN;
          end
          `SIS_C_PRESET: begin
            mpos <= tgt;
            invalid <= 1'b0;
          end
          `SIS_C_CSTOP: stop_req <= 1'b1;
          default: cmd_err <= 1'b1;
        endcase
      end
      if (idx_pend && start_ev && st == S_IDLE && !estop) begin
        idx_pend <= 1'b0;
        rem <= idx_rem;
        dir <= idx_dir;
        seg_n <= 2'h0;
        seg_i <= 2'h0;
        st <= S_RUN;
      end
      // stall and e-stop override the state set by any command taken in the same cycle
      if (estop || ot_fault) st <= S_IDLE;
      if (stall_ev) begin
        stall <= 1'b1;
        invalid <= 1'b1;
        st <= S_IDLE;
      end
    end
  end

  // ------------------------------------------------------------
  // temperature and current control
  // ------------------------------------------------------------
  always @(posedge sys_clk_i) begin
    if (!rst_n_i) begin
      ot_warn <= 1'b0;
      ot_fault <= 1'b0;
      motor_en_o <= 1'b0;
      idle_cnt <= 32'h0;
      idle <= 1'b0;
      peak_mode_o <= 1'b0;
      cur_ma_o <= 13'h0;
    end else begin
      ot_warn <= (tmp_s2 >= `SIS_TEMP_WRN);
      // fault releases only once the part has cooled below the warning level
      if (tmp_s2 > `SIS_TEMP_MAX) ot_fault <= 1'b1;
      else if (tmp_s2 < `SIS_TEMP_WRN) ot_fault <= 1'b0;
      motor_en_o <= ~ot_fault & (tmp_s2 <= `SIS_TEMP_MAX);
      if (moving) begin
        idle_cnt <= 32'h0;
        idle <= 1'b0;
      end else if (idle_cnt >= IDLE_CYC - 1) begin
        idle <= 1'b1;
      end else begin
        idle_cnt <= idle_cnt + 32'h1;
      end
      peak_mode_o <= idle;
      cur_ma_o <= idle ? cur[5:0] * cur[14:8] : cur[5:0] * `SIS_PCT_MAX;
    end
  end
endmodule // sis_top

// [test/sis_chk_sva.sv]
`timescale 1ns/100ps
module sis_chk #(
  parameter IDLE_CYC = 50
) (
  input wire        sys_clk_i,
  input wire        rst_n_i,
  input wire [31:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire        wb_we_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire        wb_ack_o,
  input wire [7:0]  temp_i,
  input wire        step_o,
  input wire        motor_en_o,
  input wire        peak_mode_o,
  input wire [12:0] cur_ma_o
);
  // ----
  // cycles since the last step; slack of two for pulse latency
  // ----
  wire       take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  reg [31:0] still;
  always @(posedge sys_clk_i) begin
    if (!rst_n_i || step_o)
      still <= 32'h0;
    else
      still <= still + 32'h1;
  end
  default clocking dcb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  bus_ack_a: assert property (take |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one cycle after request");
  unmap_read_a: assert property (take && !wb_we_i && wb_adr_i[31:8] != 24'h0 |=> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  temp_cut_a: assert property ((temp_i > 8'h5F) [*6] |-> !motor_en_o)
    else $error("motor powered while hot");
  run_current_a: assert property (motor_en_o && !peak_mode_o |->
    cur_ma_o >= 13'h64 && cur_ma_o <= 13'hD48 && cur_ma_o % 100 == 0)
    else $error("run current off grid");
  idle_level_a: assert property ($rose(peak_mode_o) |-> cur_ma_o <= $past(cur_ma_o))
    else $error("idle current above run");
  idle_delay_a: assert property ($rose(peak_mode_o) |-> still >= IDLE_CYC - 2)
    else $error("idle entered too early");
  step_full_a: assert property (step_o |-> !peak_mode_o)
    else $error("step under idle regulation");
  stop_halt_a: assert property (take && wb_we_i && wb_adr_i == 32'h4 &&
    wb_dat_i[3:0] == 4'h7 |=> ##1 (!step_o) [*8])
    else $error("step after immediate stop");
endmodule // sis_chk
bind sis_top sis_chk #(.IDLE_CYC(IDLE_CYC)) u_chk (
  .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
  .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .temp_i(temp_i), .step_o(step_o), .motor_en_o(motor_en_o),
  .peak_mode_o(peak_mode_o), .cur_ma_o(cur_ma_o));

// [test/sis_host.sv]
`timescale 1ns/100ps
module sis_host (
  input  wire        clk_i,
  input  wire        ack_i,
  input  wire [31:0] dat_i,
  output reg  [31:0] adr_o,
  output reg  [31:0] dat_o,
  output reg  [3:0]  sel_o,
  output reg         we_o,
  output reg         cyc_o
);
  // ----
  // released address, data and write lines show the inverse; sel_o keeps its last value
  // ----
  initial begin
    {adr_o, dat_o, sel_o, we_o, cyc_o} = 70'h0;
  end
  task acc(input [31:0] a, input [31:0] d, input w, output [31:0] r);
    begin
      @(posedge clk_i);
      adr_o <= a;
      dat_o <= d;
      sel_o <= 4'hF;
      we_o <= w;
      cyc_o <= 1'b1;
      @(posedge clk_i);
      while (ack_i !== 1'b1)
        @(posedge clk_i);
      r = dat_i;
      cyc_o <= 1'b0;
      adr_o <= ~a;
      dat_o <= ~d;
      we_o <= ~w;
    end
  endtask
endmodule // sis_host

// [test/stepper_indexer_supervisor_test.sv]
`timescale 1ns/100ps
`include "sis_map.vh"
module stepper_indexer_supervisor_test;
  reg         sys_clk_i = 1'b0;
  reg         rst_n_i = 1'b0;
  reg  [1:0]  din_i = 2'h0;
  reg  [31:0] enc_pos_i = 32'h0;
  reg  [7:0]  temp_i = 8'h19;
  reg         enc_fit = 1'b1;
  reg         gap_clr = 1'b0;
  wire [31:0] adr;
  wire [31:0] wdat;
  wire [31:0] rdat;
  wire [3:0]  sel;
  wire        we;
  wire        cyc;
  wire        ack;
  wire        step_o;
  wire        dir_o;
  wire        motor_en_o;
  wire        peak_mode_o;
  wire [12:0] cur_ma_o;
  reg  [31:0] q;
  integer     n_mismatch = 0;
  integer     n_tests = 0;
  integer     n_step = 0;
  integer     gap = 0;
  integer     gmax = 0;
  integer     s;
  always #2 sys_clk_i = ~sys_clk_i;
  sis_host host (.clk_i(sys_clk_i), .ack_i(ack), .dat_i(rdat), .adr_o(adr), .dat_o(wdat),
    .sel_o(sel), .we_o(we), .cyc_o(cyc));
  sis_top #(.IDLE_CYC(50)) DUT (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .wb_adr_i(adr),
    .wb_dat_i(wdat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(cyc),
    .wb_dat_o(rdat), .wb_ack_o(ack), .din_i(din_i), .enc_fitted_i(enc_fit),
    .enc_pos_i(enc_pos_i), .temp_i(temp_i), .step_o(step_o), .dir_o(dir_o),
    .motor_en_o(motor_en_o), .peak_mode_o(peak_mode_o), .cur_ma_o(cur_ma_o));
  // ----
  // step count and longest pause between steps
  // ----
  always @(posedge sys_clk_i) begin
    if (gap_clr) begin
      gap <= 0;
      gmax <= 0;
    end else if (step_o === 1'b1) begin
      n_step <= n_step + 1;
      gmax <= (gap > gmax) ? gap : gmax;
      gap <= 0;
    end else begin
      gap <= gap + 1;
    end
  end
  task tick(input integer n);
    repeat (n) @(posedge sys_clk_i);
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    begin
      n_tests = n_tests + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [5:0] a, input [31:0] d);
    host.acc({24'h0, a, 2'h0}, d, 1'b1, q);
  endtask
  task rdc(input [5:0] a, input [31:0] m, input [31:0] e);
    begin
      host.acc({24'h0, a, 2'h0}, 32'h0, 1'b0, q);
      chk(q & m, e);
    end
  endtask
  task mv(input [31:0] t, input [31:0] c);
    begin
      wr(`SIS_A_TGT, t);
      s = n_step;
      wr(`SIS_A_CMD, c);
    end
  endtask
  task step_seen;
    begin
      repeat (500) if (step_o !== 1'b1) @(posedge sys_clk_i);
      chk(step_o, 32'h1);
    end
  endtask
  task idle_wait;
    begin
      q = 32'h0;
      repeat (400) if (q[9] !== 1'b1) host.acc(32'h1C, 32'h0, 1'b0, q);
      chk(q[9], 32'h1);
    end
  endtask
  task put(input [1:0] k, input [31:0] v);
    begin
      @(posedge sys_clk_i);
      if (k == 2'h0) enc_pos_i <= v;
      else if (k == 2'h1) din_i[0] <= v[0];
      else temp_i <= v[7:0];
    end
  endtask
  task t_idle;
    begin
      chk(cur_ma_o, 32'h3E8);
      tick(60);
      chk(peak_mode_o, 32'h1);
      chk(cur_ma_o, 32'h64);
      rdc(`SIS_A_CUR, ~32'h0, 32'h0A0A);
      host.acc(32'h100, 32'h0, 1'b0, q);
      chk(q, 32'h0);
      wr(`SIS_A_CUR, 32'h7828);
      rdc(`SIS_A_CUR, ~32'h0, 32'h6422);
      wr(`SIS_A_CUR, 32'h1905);
      tick(3);
      chk(cur_ma_o, 32'h7D);
      wr(`SIS_A_PER, 32'h3);
      $display("idle test done");
    end
  endtask
  task t_seg(input [31:0] c, input [31:0] mp);
    begin
      wr(`SIS_A_TGT, 32'h0);
      wr(`SIS_A_SEG, 32'h2);
      wr(`SIS_A_TGT, 32'h1);
      wr(`SIS_A_SEG, 32'h3);
      mv(32'h1, c);
      gap_clr <= 1'b1;
      tick(1);
      gap_clr <= 1'b0;
      tick(1);
      chk(cur_ma_o, 32'h1F4);
      idle_wait;
      chk(n_step - s, 32'h5);
      rdc(`SIS_A_MPOS, ~32'h0, mp);
      $display("segment test done");
    end
  endtask
  task t_stall;
    begin
      put(2'h0, 32'd131);
      wr(`SIS_A_CTRL, 32'h1);
      tick(10);
      rdc(`SIS_A_STAT, 32'h3, 32'h0);
      @(posedge sys_clk_i) enc_fit <= 1'b0;
      put(2'h0, 32'd132);
      tick(10);
      rdc(`SIS_A_STAT, 32'h3, 32'h0);
      @(posedge sys_clk_i) enc_fit <= 1'b1;
      tick(10);
      rdc(`SIS_A_STAT, 32'h3, 32'h3);
      mv(32'h3, 32'h8);
      tick(30);
      rdc(`SIS_A_STAT, 32'h4, 32'h4);
      chk(n_step - s, 32'h0);
      put(2'h0, 32'd31);
      wr(`SIS_A_STAT, 32'h5);
      mv(32'd1000, 32'hB);
      step_seen;
      put(2'h0, 32'd2000);
      tick(20);
      s = n_step;
      tick(40);
      chk(n_step - s, 32'h0);
      wr(`SIS_A_CTRL, 32'h0);
      mv(32'h0, 32'h9);
      rdc(`SIS_A_STAT, 32'h2, 32'h0);
      mv(32'h3, 32'h8);
      idle_wait;
      rdc(`SIS_A_MPOS, ~32'h0, 32'h3);
      $display("stall test done");
    end
  endtask
  task t_hold;
    begin
      mv(32'hC, 32'hB);
      step_seen;
      wr(`SIS_A_CMD, 32'h5);
      s = n_step;
      tick(30);
      chk(n_step - s, 32'h0);
      rdc(`SIS_A_STAT, 32'h100, 32'h100);
      wr(`SIS_A_CMD, 32'h6);
      idle_wait;
      rdc(`SIS_A_MPOS, ~32'h0, 32'hF);
      mv(32'd1000, 32'hB);
      step_seen;
      wr(`SIS_A_CMD, 32'h7);
      s = n_step;
      tick(30);
      chk(n_step - s, 32'h0);
      $display("hold and stop test done");
    end
  endtask
  task t_reg;
    begin
      wr(`SIS_A_PER, 32'h14);
      mv(32'h2, 32'h11);
      step_seen;
      chk(dir_o, 32'h1);
      mv(32'h2, 32'hA);
      idle_wait;
      chk(n_step - s, 32'h2);
      wr(`SIS_A_PER, 32'h3);
      $display("registration test done");
    end
  endtask
  task t_index;
    begin
      wr(`SIS_A_INCFG, 32'h9);
      mv(32'h3, 32'h4);
      tick(30);
      chk(n_step - s, 32'h0);
      rdc(`SIS_A_STAT, 32'h420, 32'h420);
      put(2'h1, 32'h1);
      tick(30);
      chk(n_step - s, 32'h0);
      put(2'h1, 32'h0);
      tick(40);
      chk(n_step - s, 32'h3);
      $display("indexer test done");
    end
  endtask
  task t_inp;
    begin
      wr(`SIS_A_INCFG, 32'h30);
      mv(32'd1000, 32'hB);
      step_seen;
      @(posedge sys_clk_i) din_i[1] <= 1'b1;
      tick(10);
      s = n_step;
      tick(30);
      chk(n_step - s, 32'h0);
      mv(32'h5, 32'hB);
      tick(30);
      chk(n_step - s, 32'h0);
      @(posedge sys_clk_i) din_i[1] <= 1'b0;
      wr(`SIS_A_INCFG, 32'h20);
      wr(`SIS_A_PER, 32'h14);
      mv(32'h2, 32'h1);
      step_seen;
      wr(`SIS_A_TGT, 32'h2);
      s = n_step;
      @(posedge sys_clk_i) din_i[1] <= 1'b1;
      idle_wait;
      chk(n_step - s, 32'h2);
      @(posedge sys_clk_i) din_i[1] <= 1'b0;
      wr(`SIS_A_PER, 32'h3);
      $display("input function test done");
    end
  endtask
  task t_ot;
    begin
      put(2'h2, 32'h5A);
      tick(10);
      rdc(`SIS_A_STAT, 32'h18, 32'h8);
      put(2'h2, 32'h60);
      tick(10);
      chk(motor_en_o, 32'h0);
      put(2'h2, 32'h19);
      tick(10);
      chk(motor_en_o, 32'h1);
      $display("temperature test done");
    end
  endtask
  task final_report;
    begin
      $display("tests %0d mismatches %0d", n_tests, n_mismatch);
      if (n_mismatch == 0 && n_tests > 0)
        $display("DONE - PASS");
      else
        $display("DONE - FAIL");
      $finish;
    end
  endtask
  initial begin
    tick(8);
    rst_n_i <= 1'b1;
    tick(2);
    t_idle;
    t_seg(32'h102, 32'h5);
    chk(gmax, 32'h3);
    wr(`SIS_A_DWELL, 32'd40);
    t_seg(32'h103, 32'hA);
    chk(gmax >= 40, 32'h1);
    t_stall;
    t_hold;
    t_reg;
    t_index;
    t_inp;
    t_ot;
    final_report;
  end
  initial begin
    #200000;
    n_mismatch = n_mismatch + 1;
    final_report;
  end
endmodule // stepper_indexer_supervisor_test
